// >>> dacr_pkg.sv
// Package with constants, field layouts and types of the dual converter register bank.
//
// Contract
// R1 - Every access begins with a command write.
// R2 - Command byte selects direction and target register.
// R3 - Read-only status byte, resets to zero; the bank reads i_status directly and never resets it.
// R4 - Status reports missing reference among other flags.
// R5 - Mode register byte, resets to zero.
// R6 - Main converter control byte, resets to 0x07.
// R7 - Aux converter control byte, resets to 0x01.
// R8 - Sixteen-bit I/O control word, resets to zero.
// R9 - Filter word byte, resets to 0x45.
// R10 - One filter word drives both converters.
// R11 - Host keeps filter word within 13 to 255.
// R12 - After access, interface returns to idle.
// R13 - Thirty-two clocks with data high reset all.
// R14 - Command byte shifted most significant bit first.
// R15 - Fixed zero bits read back as zero.
// R16 - Reset restores defaults; command keeps nothing readable.
package dacr_pkg;
   // Register addresses carried in the low nibble of the command byte.
   localparam logic [3:0] DACR_ADDR_CMD = 4'h0;
   localparam logic [3:0] DACR_ADDR_STATUS = 4'h0;
   localparam logic [3:0] DACR_ADDR_MODE = 4'h1;
   localparam logic [3:0] DACR_ADDR_MAIN = 4'h2;
   localparam logic [3:0] DACR_ADDR_AUX = 4'h3;
   localparam logic [3:0] DACR_ADDR_IO = 4'h4;
   localparam logic [3:0] DACR_ADDR_FILT = 4'h7;
   // Command byte fields.
   localparam int DACR_CMD_WEN_BIT = 7;
   localparam int DACR_CMD_RD_BIT = 6;
   // Reset values.
   localparam logic [7:0] DACR_RST_STATUS = 8'h00;
   localparam logic [7:0] DACR_RST_MODE = 8'h00;
   localparam logic [7:0] DACR_RST_MAIN = 8'h07;
   localparam logic [7:0] DACR_RST_AUX = 8'h01;
   localparam logic [15:0] DACR_RST_IO = 16'h0000;
   localparam logic [7:0] DACR_RST_FILT = 8'h45;
   // Writable bit masks; zero positions are forced to zero.
   localparam logic [7:0] DACR_MASK_MODE = 8'h5f;
   localparam logic [7:0] DACR_MASK_AUX = 8'hf9;
   localparam logic [15:0] DACR_MASK_IO = 16'hdfff;
   // Serial resync: data held high for this many serial clocks.
   localparam logic [5:0] DACR_RESYNC_CLKS = 6'd32;
   localparam logic [4:0] DACR_LAST_BIT_8 = 5'd7;
   localparam logic [4:0] DACR_LAST_BIT_16 = 5'd15;

   typedef enum logic [1:0] {
      DACR_IDLE,
      DACR_WRITE,
      DACR_READ
   } dacr_state_e;

   typedef struct packed {
      logic main_result_ready;
      logic aux_result_ready;
      logic cal_active;
      logic reference_missing;
      logic main_fault;
      logic aux_fault;
      logic pll_locked;
   } dacr_status_s;
endpackage

// >>> dacr_regs.sv
// Serial-accessed control and status register bank of a dual converter front end.
`timescale 1ns/10ps
`default_nettype none
module dacr_regs
   import dacr_pkg::*;
(
   // Clock and reset.
   input wire logic i_mclk,
   input wire logic i_rst,
   // Serial link from the host.
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_din,
   output logic o_dout,
   // Converter state reported in the status byte.
   input wire dacr_status_s i_status,
   // Register contents delivered to the converter logic.
   output logic [7:0] o_operating_mode,
   output logic [7:0] o_main_converter_control,
   output logic [7:0] o_aux_converter_control,
   output logic [15:0] o_io_and_excitation_control,
   output logic [7:0] o_main_filter_word,
   output logic [7:0] o_aux_filter_word,
   output logic o_busy
);

   ////////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: three stages, a change counts when stages two and three agree.
   logic [2:0] sclk_sync_reg;
   logic [2:0] cs_sync_reg;
   logic [2:0] din_sync_reg;
   logic sclk_reg;
   logic cs_n_reg;
   logic din_reg;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sclk_sync_reg <= 3'b111;
         cs_sync_reg <= 3'b111;
         din_sync_reg <= 3'b000;
         sclk_reg <= 1'b1;
         cs_n_reg <= 1'b1;
         din_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[1:0], i_sclk};
         cs_sync_reg <= {cs_sync_reg[1:0], i_cs_n};
         din_sync_reg <= {din_sync_reg[1:0], i_din};
         if (sclk_sync_reg[1] == sclk_sync_reg[2]) begin
            sclk_reg <= sclk_sync_reg[2];
         end
         if (cs_sync_reg[1] == cs_sync_reg[2]) begin
            cs_n_reg <= cs_sync_reg[2];
         end
         if (din_sync_reg[1] == din_sync_reg[2]) begin
            din_reg <= din_sync_reg[2];
         end
      end
   end

   logic sclk_seen_reg;
   logic sclk_rise;
   logic sclk_fall;
   logic active;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         sclk_seen_reg <= 1'b1;
      end else begin
         sclk_seen_reg <= sclk_reg;
      end
   end

   assign sclk_rise = sclk_reg & ~sclk_seen_reg;
   assign sclk_fall = ~sclk_reg & sclk_seen_reg;
   assign active = ~cs_n_reg;

   ////////////////////////////////////////////////////////////////////////////////
   // Resync detector: a long run of high data bits resets the whole bank.
   logic [5:0] ones_reg;
   logic resync;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         ones_reg <= '0;
      end else if (resync) begin
         ones_reg <= '0;
      end else if (active && sclk_rise) begin
         ones_reg <= din_reg ? ones_reg + 6'd1 : 6'd0;
      end
   end

   assign resync = (ones_reg == DACR_RESYNC_CLKS); // [R13]

   ////////////////////////////////////////////////////////////////////////////////
   // Transaction state and shift logic.
   dacr_state_e state_reg;
   logic [4:0] bit_reg;
   logic [7:0] cmd_shift_reg;
   logic [15:0] data_shift_reg;
   logic [3:0] target_reg;
   logic [4:0] last_bit_reg;
   logic [15:0] read_word;
   logic [4:0] target_last;
   logic [7:0] cmd_next;
   logic [15:0] data_next;
   logic write_done;

   always_comb begin
      case (cmd_next[3:0])
         DACR_ADDR_IO: target_last = DACR_LAST_BIT_16;
         default: target_last = DACR_LAST_BIT_8;
      endcase
   end

   assign cmd_next = {cmd_shift_reg[6:0], din_reg}; // [R14]
   assign data_next = {data_shift_reg[14:0], din_reg};

   always_comb begin
      read_word = 16'h0000;
      case (cmd_next[3:0])
         DACR_ADDR_STATUS: read_word = {8'h00, i_status.main_result_ready,
            i_status.aux_result_ready, i_status.cal_active,
            i_status.reference_missing, i_status.main_fault, i_status.aux_fault,
            1'b0, i_status.pll_locked}; // [R3] [R4] [R15]
         DACR_ADDR_MODE: read_word = {o_operating_mode, 8'h00};
         DACR_ADDR_MAIN: read_word = {o_main_converter_control, 8'h00};
         DACR_ADDR_AUX: read_word = {o_aux_converter_control, 8'h00};
         DACR_ADDR_IO: read_word = o_io_and_excitation_control;
         DACR_ADDR_FILT: read_word = {o_main_filter_word, 8'h00};
         default: read_word = 16'h0000;
      endcase
      if (cmd_next[3:0] == DACR_ADDR_STATUS) begin
         read_word = {read_word[7:0], 8'h00};
      end
   end

   // A byte with the enable bit high is not a command, so it is dropped silently.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= DACR_IDLE;
         bit_reg <= '0;
         cmd_shift_reg <= '0;
         data_shift_reg <= '0;
         target_reg <= '0;
         last_bit_reg <= '0;
      end else if (resync || cs_n_reg) begin
         state_reg <= DACR_IDLE;
         bit_reg <= '0;
      end else if (sclk_rise) begin
         case (state_reg)
            DACR_IDLE: begin
               cmd_shift_reg <= cmd_next;
               if (bit_reg == DACR_LAST_BIT_8) begin
                  bit_reg <= '0;
                  if (!cmd_next[DACR_CMD_WEN_BIT]) begin // [R1] [R2]
                     target_reg <= cmd_next[3:0];
                     last_bit_reg <= target_last;
                     if (cmd_next[DACR_CMD_RD_BIT]) begin
                        state_reg <= DACR_READ;
                        data_shift_reg <= read_word;
                     end else begin
                        state_reg <= DACR_WRITE;
                     end
                  end
               end else begin
                  bit_reg <= bit_reg + 5'd1;
               end
            end
            DACR_WRITE: begin
               data_shift_reg <= data_next;
               if (bit_reg == last_bit_reg) begin
                  bit_reg <= '0;
                  state_reg <= DACR_IDLE; // [R12]
               end else begin
                  bit_reg <= bit_reg + 5'd1;
               end
            end
            DACR_READ: begin
               data_shift_reg <= {data_shift_reg[14:0], 1'b0};
               if (bit_reg == last_bit_reg) begin
                  bit_reg <= '0;
                  state_reg <= DACR_IDLE; // [R12]
               end else begin
                  bit_reg <= bit_reg + 5'd1;
               end
            end
            default: state_reg <= DACR_IDLE;
         endcase
      end
   end

   assign write_done = active && sclk_rise && (state_reg == DACR_WRITE) &&
      (bit_reg == last_bit_reg) && !resync;

   ////////////////////////////////////////////////////////////////////////////////
   // Data out changes on the falling serial edge, high while idle.
   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_dout <= 1'b1;
      end else if (state_reg != DACR_READ || cs_n_reg) begin
         o_dout <= 1'b1;
      end else if (sclk_fall || sclk_rise) begin
         o_dout <= data_shift_reg[15];
      end
   end

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_busy <= 1'b0;
      end else begin
         o_busy <= (state_reg != DACR_IDLE);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Register storage; only a completed write or a resync updates a register.
   logic [7:0] filter_reg;

   always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
         o_operating_mode <= DACR_RST_MODE; // [R16]
         o_main_converter_control <= DACR_RST_MAIN;
         o_aux_converter_control <= DACR_RST_AUX;
         o_io_and_excitation_control <= DACR_RST_IO;
         filter_reg <= DACR_RST_FILT;
      end else if (resync) begin
         o_operating_mode <= DACR_RST_MODE; // [R13] [R16]
         o_main_converter_control <= DACR_RST_MAIN;
         o_aux_converter_control <= DACR_RST_AUX;
         o_io_and_excitation_control <= DACR_RST_IO;
         filter_reg <= DACR_RST_FILT;
      end else if (write_done) begin
         case (target_reg)
            DACR_ADDR_MODE: o_operating_mode <= data_next[7:0] & DACR_MASK_MODE; // [R5] [R15]
            DACR_ADDR_MAIN: o_main_converter_control <= data_next[7:0]; // [R6]
            DACR_ADDR_AUX: o_aux_converter_control <= data_next[7:0] & DACR_MASK_AUX; // [R7]
            DACR_ADDR_IO: o_io_and_excitation_control <= data_next & DACR_MASK_IO; // [R8]
            DACR_ADDR_FILT: filter_reg <= data_next[7:0]; // [R9]
            default: filter_reg <= filter_reg;
         endcase
      end
   end

   // The host keeps the word in range; values below the limit are stored as written.
   assign o_main_filter_word = filter_reg; // [R10] [R11]
   assign o_aux_filter_word = filter_reg; // [R10]

endmodule
`default_nettype wire

// >>> dacr_regs_asserts.sv
// Port checks for the serial register bank.
`timescale 1ns/10ps
`default_nettype none
module dacr_regs_asserts
   import dacr_pkg::*;
(
   // Clock, reset and link.
   input wire logic i_mclk,
   input wire logic i_rst,
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_din,
   input wire logic o_dout,
   // Status and register contents.
   input wire dacr_status_s i_status,
   input wire logic [7:0] o_operating_mode,
   input wire logic [7:0] o_main_converter_control,
   input wire logic [7:0] o_aux_converter_control,
   input wire logic [15:0] o_io_and_excitation_control,
   input wire logic [7:0] o_main_filter_word,
   input wire logic [7:0] o_aux_filter_word,
   input wire logic o_busy
);
   default clocking @(posedge i_mclk); endclocking
   default disable iff (i_rst);
   // Eight cycles cover the select synchroniser before idle is demanded.
   sequence cs_idle_s;
      i_cs_n [*8];
   endsequence
   filt_shared_a: assert property (o_main_filter_word == o_aux_filter_word)
      else $error("filter words differ");
   mode_zero_a: assert property ((o_operating_mode & 8'ha0) == 8'h00)
      else $error("mode fixed bits set");
   aux_zero_a: assert property ((o_aux_converter_control & 8'h06) == 8'h00)
      else $error("aux fixed bits set");
   io_zero_a: assert property (o_io_and_excitation_control[13] == 1'b0)
      else $error("io fixed bit set");
   reset_vals_a: assert property ($fell(i_rst) |-> o_operating_mode == 8'h00 &&
      o_main_converter_control == 8'h07 && o_aux_converter_control == 8'h01 &&
      o_io_and_excitation_control == 16'h0000 && o_main_filter_word == 8'h45)
      else $error("defaults wrong after reset");
   dout_idle_a: assert property (cs_idle_s |-> o_dout)
      else $error("dout not high when idle");
   busy_idle_a: assert property (cs_idle_s |-> !o_busy)
      else $error("busy while deselected");
   hold_regs_a: assert property (cs_idle_s |=> $stable(o_operating_mode) &&
      $stable(o_io_and_excitation_control) && $stable(o_main_filter_word))
      else $error("register changed without access");
endmodule
bind dacr_regs dacr_regs_asserts chk (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(i_sclk),
   .i_cs_n(i_cs_n), .i_din(i_din), .o_dout(o_dout), .i_status(i_status),
   .o_operating_mode(o_operating_mode), .o_main_converter_control(o_main_converter_control),
   .o_aux_converter_control(o_aux_converter_control), .o_busy(o_busy),
   .o_io_and_excitation_control(o_io_and_excitation_control),
   .o_main_filter_word(o_main_filter_word), .o_aux_filter_word(o_aux_filter_word));
`default_nettype wire

// >>> dacr_host.sv
// Host model driving the four-wire serial link.
`timescale 1ns/10ps
`default_nettype none
module dacr_host (
   // System clock and answer.
   input wire logic i_mclk,
   input wire logic i_dout,
   // Link towards the device.
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din
);
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_din = 1'b0;
   end
   // Sends the low n bits of v MSB first; q holds dout taken two clocks into each high phase.
   // The device's synchroniser puts a bit out about five clocks after the falling edge,
   // so looking at the very moment of the rising edge would still see the previous bit.
   task automatic frame(input logic [31:0] v, input int n, output logic [31:0] q);
      q = 32'h0000_0000;
      o_cs_n <= 1'b0;
      repeat (4) @(posedge i_mclk);
      for (int i = n - 1; i >= 0; i--) begin
         o_din <= v[i];
         o_sclk <= 1'b0;
         repeat (4) @(posedge i_mclk);
         o_sclk <= 1'b1;
         repeat (2) @(posedge i_mclk);
         q[i] = i_dout;
         repeat (2) @(posedge i_mclk);
      end
      repeat (8) @(posedge i_mclk);
      o_cs_n <= 1'b1;
      // A released line must not keep showing the last bit.
      o_din <= ~o_din;
      repeat (8) @(posedge i_mclk);
   endtask
endmodule
`default_nettype wire

// >>> dacr_regs_tb_top.sv
// Self-checking bench for the serial register bank.
`timescale 1ns/10ps
`default_nettype none
module dacr_regs_tb_top
   import dacr_pkg::*;
;
   logic i_mclk, i_rst, sclk, cs_n, din, dout, busy;
   dacr_status_s st;
   logic [7:0] mode, mainc, auxc, mfilt, afilt;
   logic [15:0] io;
   int fail_count = 0;
   int compares = 0;
   dacr_regs DUT (.i_mclk(i_mclk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n), .i_din(din),
      .o_dout(dout), .i_status(st), .o_operating_mode(mode), .o_main_converter_control(mainc),
      .o_aux_converter_control(auxc), .o_io_and_excitation_control(io),
      .o_main_filter_word(mfilt), .o_aux_filter_word(afilt), .o_busy(busy));
   dacr_host host (.i_mclk(i_mclk), .i_dout(dout), .o_sclk(sclk), .o_cs_n(cs_n), .o_din(din));
   initial begin
      i_mclk = 1'b0;
      forever #12.5 i_mclk = ~i_mclk;
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("BAD %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic acc(input logic [3:0] a, input logic rd, input logic [15:0] wd,
      output logic [15:0] q);
      int n;
      logic [31:0] r;
      n = (a == DACR_ADDR_IO) ? 24 : 16;
      if (n == 16) wd = {8'h00, wd[7:0]};
      host.frame(({24'h00_0000, 1'b0, rd, 2'b00, a} << (n - 8)) | {16'h0000, wd}, n, r);
      q = (n == 24) ? r[15:0] : {8'h00, r[7:0]};
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [15:0] e);
      logic [15:0] q;
      acc(a, 1'b1, 16'h0000, q);
      chk(q, e);
   endtask
   task automatic wrrd(input logic [3:0] a, input logic [15:0] d, input logic [15:0] e);
      logic [15:0] q;
      acc(a, 1'b0, d, q);
      rdchk(a, e);
   endtask
   task automatic t_defaults();
      chk({mode, mainc}, 16'h0007);
      chk({auxc, afilt}, 16'h0145);
      chk(io, 16'h0000);
      rdchk(DACR_ADDR_MODE, 16'h0000);
      rdchk(DACR_ADDR_MAIN, 16'h0007);
      rdchk(DACR_ADDR_AUX, 16'h0001);
      rdchk(DACR_ADDR_IO, 16'h0000);
      rdchk(DACR_ADDR_FILT, 16'h0045);
      $display("defaults done");
   endtask
   task automatic t_status();
      logic [15:0] q;
      rdchk(DACR_ADDR_STATUS, 16'h0000);
      st <= 7'h5b;
      acc(DACR_ADDR_STATUS, 1'b0, 16'h00ff, q);
      rdchk(DACR_ADDR_STATUS, 16'h00b5);
      st <= 7'h24;
      rdchk(DACR_ADDR_STATUS, 16'h0048);
      $display("status done");
   endtask
   task automatic t_write(input logic [15:0] m, input logic [15:0] f);
      wrrd(DACR_ADDR_MODE, m, m & 16'h005f);
      wrrd(DACR_ADDR_MAIN, m, m & 16'h00ff);
      wrrd(DACR_ADDR_AUX, m, m & 16'h00f9);
      wrrd(DACR_ADDR_IO, m, m & 16'hdfff);
      wrrd(DACR_ADDR_FILT, f, f);
      chk({mainc, mode}, {m[7:0], m[7:0] & 8'h5f});
      chk({auxc, 8'h00}, {m[7:0] & 8'hf9, 8'h00});
      chk(io, m & 16'hdfff);
      chk({mfilt, afilt}, {f[7:0], f[7:0]});
      $display("write done");
   endtask
   task automatic t_misc();
      logic [31:0] r;
      host.frame(32'hffff_ffff, 32, r);
      t_defaults();
      host.frame({16'h0000, 8'h81, 8'hff}, 16, r);
      chk({8'h00, mode}, 16'h0000);
      host.frame({20'h0_0000, 8'h01, 4'hf}, 12, r);
      chk({7'h00, busy, mode}, 16'h0000);
      rdchk(DACR_ADDR_MODE, 16'h0000);
      $display("misc done");
   endtask
   task automatic complete_run();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   initial begin
      i_rst = 1'b1;
      st = 7'h00;
      repeat (12) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_mclk);
      t_defaults();
      t_status();
      t_write(16'hffff, 16'h000d);
      t_misc();
      t_write(16'ha5c3, 16'h00ff);
      i_rst <= 1'b1;
      repeat (2) @(posedge i_mclk);
      i_rst <= 1'b0;
      repeat (8) @(posedge i_mclk);
      chk({15'h0000, dout}, 16'h0001);
      t_defaults();
      complete_run();
   end
   // Whole run needs about seven thousand cycles; almost six times that means a hang.
   initial begin
      repeat (40000) @(posedge i_mclk);
      fail_count++;
      complete_run();
   end
endmodule
`default_nettype wire
